// ### src/xmb_map.vh
`ifndef XMB_MAP_VH
`define XMB_MAP_VH
// register offsets on the plain register port
`define XMB_REG_CTRL    4'h0
`define XMB_REG_TPTR_L  4'h1
`define XMB_REG_TPTR_H  4'h2
`define XMB_REG_TPTR_U  4'h3
`define XMB_REG_TLAT    4'h4
`define XMB_REG_CMD     4'h5
`define XMB_REG_STAT    4'h6
`define XMB_REG_FETCH_L 4'h7
`define XMB_REG_FETCH_H 4'h8
// control register fields
`define XMB_CTRL_WM_LO   0
`define XMB_CTRL_WAIT_LO 4
`define XMB_CTRL_RST     8'h00
// write mode codes
`define XMB_WM_BYTE_WR  2'h0
`define XMB_WM_WORD_WR  2'h1
// any code with bit 1 set is byte select
`define XMB_WM_SEL_BIT  1
// command bits
`define XMB_CMD_WRITE   0
`define XMB_CMD_READ    1
`define XMB_CMD_FETCH   2
// status bits
`define XMB_STAT_BUSY   0
`define XMB_STAT_SLEEP  1
// extra read cycles that cover the pin synchroniser
`define XMB_SYNC_CYC    3'h4
`endif

// ### src/xmb_pin_sync.v
`timescale 1ns/1ps
// three-stage synchroniser for the multiplexed bus inputs
module xmb_pin_sync
(
    input  wire        core_clk,
    input  wire        rst,
    input  wire [15:0] pin_in,
    output wire [15:0] pin_sync
);
    reg [15:0] s1_r;    // first stage, read only by the second
    reg [15:0] s2_r;    // second stage
    reg [15:0] s3_r;    // third stage
    reg [15:0] held_r;  // accepted value

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : g_bit
            // a change counts once stages two and three agree
            always @(posedge core_clk)
            begin
                if (rst)
                begin
                    s1_r[i]   <= 1'b0;
                    s2_r[i]   <= 1'b0;
                    s3_r[i]   <= 1'b0;
                    held_r[i] <= 1'b0;
                end
                else
                begin
                    s1_r[i] <= pin_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (s2_r[i] == s3_r[i])
                        held_r[i] <= s3_r[i];
                end
            end
        end
    endgenerate

    assign pin_sync = held_r;
endmodule // xmb_pin_sync

// ### src/xmb_ext_bus.v
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "xmb_map.vh"
// Summary of operation
// - bus is fixed sixteen bits wide
// - write mode field picks three write styles
// - pulse address latch strobe with address out
// - output enable after latch reads whole word
// - chip enable low throughout every access unless sleep is requested
// - chip enable held high during sleep
// - byte write puts latch byte on both lanes
// - byte write strobes high or low by lsb
// - word write even: hold byte, float, no strobe
// - word write odd: latch high, held low
// - word write strobes high only
// - word write odd: lsb on byte line, both enables
// - word write still allows fetches and reads
// - byte select: both lanes, high strobe only
// - byte select picks byte by lsb
// - byte select and word write drive byte address line
// - wait field adds zero to three cycles to table reads and writes
// - idle pins float or sit at rest levels
module xmb_ext_bus
(
    input  wire        core_clk,
    input  wire        rst,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        sleep_req,
    input  wire [15:0] muxed_addr_data_bus_in,
    output reg  [15:0] muxed_addr_data_bus_out,
    output reg         muxed_addr_data_bus_oe,
    output reg  [3:0]  upper_addr_out,
    output reg         upper_addr_oe,
    output reg         address_latch_strobe,
    output reg         output_enable_n,
    output reg         chip_enable_n,
    output reg         write_high_strobe_n,
    output reg         write_low_strobe_n,
    output reg         upper_byte_enable_n,
    output reg         lower_byte_enable_n,
    output reg         byte_address_line
);
    // bus cycle states
    localparam ST_IDLE = 3'h0;
    localparam ST_ALE  = 3'h1;
    localparam ST_HOLD = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_END  = 3'h4;

    // operation kinds
    localparam OP_WRITE = 2'h0;
    localparam OP_READ  = 2'h1;
    localparam OP_FETCH = 2'h2;

    reg  [7:0]  ctrl_r;          // write mode and wait count
    reg  [19:0] table_pointer_r; // table pointer
    reg  [7:0]  table_latch_r;   // table latch byte
    reg  [7:0]  hold_latch_r;    // word write low byte store
    reg  [15:0] fetch_word_r;    // last fetched word
    reg  [2:0]  state_r;         // bus state
    reg  [2:0]  state_nxt;
    reg  [1:0]  op_r;            // current operation
    reg  [2:0]  cnt_r;           // data phase counter
    reg  [2:0]  cnt_nxt;
    reg  [15:0] pin_data;        // bus value to drive next

    wire [15:0] bus_sync;        // synchronised bus input
    wire [1:0]  write_mode;      // write mode select
    wire [1:0]  bus_wait_count;  // wait field
    wire [2:0]  wait_cyc;        // wait cycles for table ops
    wire        lsb;             // table pointer bit 0
    wire        mode_sel;        // byte select mode
    wire        mode_word;       // word write mode
    wire        busy;            // a bus cycle is in progress
    wire        cmd_wr;          // command register written
    wire        start;           // accept a new cycle
    wire        wr_even_word;    // word write to an even address

    assign write_mode     = ctrl_r[`XMB_CTRL_WM_LO +: 2];
    assign bus_wait_count = ctrl_r[`XMB_CTRL_WAIT_LO +: 2];
    // 11 gives none, 00 gives three
    assign wait_cyc       = {1'b0, ~bus_wait_count};
    assign lsb            = table_pointer_r[0];
    assign mode_sel       = write_mode[`XMB_WM_SEL_BIT];
    assign mode_word      = ~mode_sel &
                            (write_mode == `XMB_WM_WORD_WR);
    assign busy           = (state_r != ST_IDLE);
    assign cmd_wr         = reg_wr & (reg_addr == `XMB_REG_CMD);
    // no cycle starts while asleep or busy
    assign start          = cmd_wr & ~busy & ~sleep_req;
    assign wr_even_word   = (op_r == OP_WRITE) & mode_word & ~lsb;

    // bus input synchroniser
    xmb_pin_sync u_sync
    (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (muxed_addr_data_bus_in),
        .pin_sync (bus_sync)
    );

    // next state and data phase length
    always @*
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_IDLE:
            begin
                if (start)
                    state_nxt = ST_ALE;
            end
            ST_ALE:
            begin
                state_nxt = ST_HOLD;
            end
            ST_HOLD:
            begin
                // fetches take no wait states
                state_nxt = ST_DATA;
                if (op_r == OP_FETCH)
                    cnt_nxt = `XMB_SYNC_CYC;
                else if (op_r == OP_READ)
                    cnt_nxt = wait_cyc + `XMB_SYNC_CYC;
                else
                    cnt_nxt = wait_cyc;
            end
            ST_DATA:
            begin
                if (cnt_r == 3'h0)
                    state_nxt = ST_END;
                else
                    cnt_nxt = cnt_r - 3'h1;
            end
            ST_END:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // state, counter and operation
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= 3'h0;
            op_r    <= OP_WRITE;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            if (start)
            begin
                // fetch wins, then read, then write
                if (reg_wdata[`XMB_CMD_FETCH])
                    op_r <= OP_FETCH;
                else if (reg_wdata[`XMB_CMD_READ])
                    op_r <= OP_READ;
                else
                    op_r <= OP_WRITE;
            end
        end
    end

    // software registers and captured data
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_r          <= `XMB_CTRL_RST;
            table_pointer_r <= 20'h00000;
            table_latch_r   <= 8'h00;
            hold_latch_r    <= 8'h00;
            fetch_word_r    <= 16'h0000;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `XMB_REG_CTRL:
                        ctrl_r <= reg_wdata & 8'h33;
                    `XMB_REG_TPTR_L:
                        table_pointer_r[7:0] <= reg_wdata;
                    `XMB_REG_TPTR_H:
                        table_pointer_r[15:8] <= reg_wdata;
                    `XMB_REG_TPTR_U:
                        table_pointer_r[19:16] <= reg_wdata[3:0];
                    `XMB_REG_TLAT:
                        table_latch_r <= reg_wdata;
                    default:
                        ;
                endcase
            end
            // even word write only loads the holding latch
            if (state_r == ST_HOLD && wr_even_word)
                hold_latch_r <= table_latch_r;
            // end state: the word has cleared all three sync stages
            if (state_r == ST_END)
            begin
                if (op_r == OP_FETCH)
                    fetch_word_r <= bus_sync;
                else if (op_r == OP_READ)
                    // bit 0 set selects the upper byte
                    table_latch_r <= lsb ? bus_sync[15:8]
                                         : bus_sync[7:0];
            end
        end
    end

    // bus value per state and mode
    always @*
    begin
        pin_data = table_pointer_r[15:0];
        if (state_r == ST_DATA || state_r == ST_END)
        begin
            if (mode_word)
                // odd half carries latch high, held byte low
                pin_data = {table_latch_r, hold_latch_r};
            else
                // byte write and byte select copy both lanes
                pin_data = {table_latch_r, table_latch_r};
        end
    end

    // registered pins, one cycle behind the state
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            muxed_addr_data_bus_out <= 16'h0000;
            muxed_addr_data_bus_oe  <= 1'b0;
            upper_addr_out          <= 4'h0;
            upper_addr_oe           <= 1'b0;
            address_latch_strobe    <= 1'b0;
            output_enable_n         <= 1'b1;
            chip_enable_n           <= 1'b1;
            write_high_strobe_n     <= 1'b1;
            write_low_strobe_n      <= 1'b1;
            upper_byte_enable_n     <= 1'b1;
            lower_byte_enable_n     <= 1'b1;
            byte_address_line       <= 1'b0;
        end
        else
        begin
            // rest levels outside a bus cycle
            muxed_addr_data_bus_out <= 16'h0000;
            muxed_addr_data_bus_oe  <= 1'b0;
            upper_addr_out          <= 4'h0;
            upper_addr_oe           <= 1'b0;
            address_latch_strobe    <= 1'b0;
            output_enable_n         <= 1'b1;
            chip_enable_n           <= 1'b1;
            write_high_strobe_n     <= 1'b1;
            write_low_strobe_n      <= 1'b1;
            upper_byte_enable_n     <= 1'b1;
            lower_byte_enable_n     <= 1'b1;
            byte_address_line       <= 1'b0;
            if (busy)
            begin
                // chip enabled for every access, reads or writes, while no sleep is requested
                chip_enable_n  <= sleep_req;
                upper_addr_out <= table_pointer_r[19:16];
                upper_addr_oe  <= 1'b1;
                // whole sixteen-bit word on the bus
                muxed_addr_data_bus_out <= pin_data;
                if (state_r == ST_ALE)
                begin
                    address_latch_strobe   <= 1'b1;
                    muxed_addr_data_bus_oe <= 1'b1;
                end
                else if (state_r == ST_HOLD)
                begin
                    // address held past the latch edge
                    muxed_addr_data_bus_oe <= 1'b1;
                end
                else if (op_r != OP_WRITE)
                begin
                    // memory drives both bytes together
                    if (state_r == ST_DATA)
                        output_enable_n <= 1'b0;
                    upper_byte_enable_n <= 1'b0;
                    lower_byte_enable_n <= 1'b0;
                end
                else if (wr_even_word)
                begin
                    // data phase floats, no strobe
                    muxed_addr_data_bus_oe <= 1'b0;
                    byte_address_line      <= lsb;
                end
                else
                begin
                    muxed_addr_data_bus_oe <= 1'b1;
                    if (mode_sel)
                    begin
                        // byte line or byte enables pick the byte
                        byte_address_line   <= lsb;
                        upper_byte_enable_n <= ~lsb;
                        lower_byte_enable_n <= lsb;
                        if (state_r == ST_DATA)
                            write_high_strobe_n <= 1'b0;
                    end
                    else if (mode_word)
                    begin
                        // both bytes selected, lsb shown only
                        byte_address_line   <= lsb;
                        upper_byte_enable_n <= 1'b0;
                        lower_byte_enable_n <= 1'b0;
                        if (state_r == ST_DATA)
                            write_high_strobe_n <= 1'b0;
                    end
                    else if (state_r == ST_DATA)
                    begin
                        // one strobe per byte write, by lsb
                        upper_byte_enable_n <= 1'b0;
                        lower_byte_enable_n <= 1'b0;
                        write_high_strobe_n <= ~lsb;
                        write_low_strobe_n  <= lsb;
                    end
                    else
                    begin
                        upper_byte_enable_n <= 1'b0;
                        lower_byte_enable_n <= 1'b0;
                    end
                end
            end
        end
    end

    // register read data, one cycle after the strobe
    always @(posedge core_clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `XMB_REG_CTRL:    reg_rdata <= ctrl_r;
                `XMB_REG_TPTR_L:  reg_rdata <= table_pointer_r[7:0];
                `XMB_REG_TPTR_H:  reg_rdata <= table_pointer_r[15:8];
                `XMB_REG_TPTR_U:  reg_rdata <= {4'h0,
                                      table_pointer_r[19:16]};
                `XMB_REG_TLAT:    reg_rdata <= table_latch_r;
                `XMB_REG_STAT:    reg_rdata <= {6'h00, sleep_req, busy};
                `XMB_REG_FETCH_L: reg_rdata <= fetch_word_r[7:0];
                `XMB_REG_FETCH_H: reg_rdata <= fetch_word_r[15:8];
                default:          reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end
endmodule // xmb_ext_bus

// ### test/xmb_ext_bus_assertions.sv
`timescale 1ns/1ps
// pin protocol checks for the external bus block
module xmb_bus_chk
(
    input wire core_clk,
    input wire rst,
    input wire sleep_req,
    input wire muxed_addr_data_bus_oe,
    input wire upper_addr_oe,
    input wire address_latch_strobe,
    input wire output_enable_n,
    input wire chip_enable_n,
    input wire write_high_strobe_n,
    input wire write_low_strobe_n,
    input wire upper_byte_enable_n,
    input wire lower_byte_enable_n,
    input wire byte_address_line
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire       wr_any;   // either write strobe low
    wire       calm;     // no sleep now or in the last two cycles
    reg  [1:0] slp_r;    // sleep history
    reg  [2:0] wr_len_r; // length of the current strobe run
    assign wr_any = !write_high_strobe_n || !write_low_strobe_n;
    assign calm = !sleep_req && slp_r == 2'b00;
    // sleep history and saturating strobe run length
    always @(posedge core_clk)
    begin
        slp_r <= {slp_r[0], sleep_req};
        if (rst || !wr_any)
            wr_len_r <= 3'h0;
        else if (wr_len_r != 3'h7)
            wr_len_r <= wr_len_r + 3'h1;
    end
    ale_pulse_a: assert property (
        address_latch_strobe |=> !address_latch_strobe)
        else $error("address strobe wider than one cycle");
    ale_addr_a: assert property (
        address_latch_strobe |-> muxed_addr_data_bus_oe && upper_addr_oe
        && output_enable_n && !wr_any)
        else $error("address strobe without address driven");
    ale_first_a: assert property (
        $rose(wr_any) |-> $past(address_latch_strobe, 2))
        else $error("write data not two cycles after address strobe");
    ce_access_a: assert property (
        calm && (address_latch_strobe || wr_any || !output_enable_n)
        |-> !chip_enable_n)
        else $error("chip enable idle during an access");
    ce_sleep_a: assert property (
        sleep_req && $past(sleep_req) |-> chip_enable_n)
        else $error("chip enable active in sleep");
    oe_word_a: assert property (
        !output_enable_n |-> !muxed_addr_data_bus_oe
        && !upper_byte_enable_n && !lower_byte_enable_n)
        else $error("read without both bytes enabled");
    wr_bus_a: assert property (
        wr_any |-> muxed_addr_data_bus_oe && output_enable_n)
        else $error("write strobe with bus not driven");
    low_only_a: assert property (
        !write_low_strobe_n |-> write_high_strobe_n && !byte_address_line)
        else $error("low strobe outside byte write use");
    wait_span_a: assert property (
        wr_len_r <= 3'h4)
        else $error("write strobe longer than three waits");
    idle_rest_a: assert property (
        calm && chip_enable_n && $past(chip_enable_n)
        |-> !muxed_addr_data_bus_oe && !upper_addr_oe && output_enable_n
        && !address_latch_strobe && !wr_any && upper_byte_enable_n
        && lower_byte_enable_n && !byte_address_line)
        else $error("idle pins not at rest");
    cover property (!write_low_strobe_n);
    cover property (!write_high_strobe_n && byte_address_line);
    cover property (!output_enable_n);
    cover property (sleep_req && !chip_enable_n);
endmodule // xmb_bus_chk

bind xmb_ext_bus xmb_bus_chk u_chk
(
    .core_clk(core_clk), .rst(rst), .sleep_req(sleep_req),
    .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe),
    .upper_addr_oe(upper_addr_oe),
    .address_latch_strobe(address_latch_strobe),
    .output_enable_n(output_enable_n), .chip_enable_n(chip_enable_n),
    .write_high_strobe_n(write_high_strobe_n),
    .write_low_strobe_n(write_low_strobe_n),
    .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n),
    .byte_address_line(byte_address_line)
);

// ### test/xmb_mem_model.sv
`timescale 1ns/1ps
// word-wide external memory as seen from the device pins
module xmb_mem_model
(
    input  wire        core_clk,
    input  wire [15:0] bus_out,
    input  wire        bus_oe,
    input  wire        ale,
    input  wire        oe_n,
    input  wire        ce_n,
    input  wire        ub_n,
    input  wire        lb_n,
    output wire [15:0] bus_in
);
    reg  [15:0] addr_r;           // address caught on the strobe
    reg  [15:0] pat_r = 16'h6b2d; // churning filler for a floating bus
    wire        drv;              // memory drives the lanes
    wire [15:0] word;             // stored word at the latched address
    assign drv = !oe_n && !ce_n;
    assign word = addr_r ^ 16'h3c5a;
    // latch the address and churn the filler every cycle
    always @(posedge core_clk)
    begin
        if (ale)
            addr_r <= bus_out;
        pat_r <= ~{pat_r[14:0], pat_r[15]};
    end
    // each lane answers only under its own byte enable
    assign bus_in[15:8] = bus_oe ? bus_out[15:8] :
                          (drv && !ub_n) ? word[15:8] : pat_r[15:8];
    assign bus_in[7:0] = bus_oe ? bus_out[7:0] :
                         (drv && !lb_n) ? word[7:0] : pat_r[7:0];
endmodule // xmb_mem_model

// ### test/test_ext_mem_bus_16bit_modes.sv
`timescale 1ns/1ps
`include "xmb_map.vh"
// random and corner bus cycles against the memory model
module test_ext_mem_bus_16bit_modes;
    reg         core_clk = 1'b0;   // bus clock
    reg         rst = 1'b1;        // sync reset
    reg  [3:0]  reg_addr = 4'h0;   // register index
    reg  [7:0]  reg_wdata = 8'h00; // register write data
    reg         reg_wr = 1'b0;     // write strobe
    reg         reg_rd = 1'b0;     // read strobe
    reg         sleep_req = 1'b0;  // sleep level
    wire [7:0]  reg_rdata;         // register read data
    wire [15:0] bus_in, bus_out;   // shared address and data lanes
    wire [3:0]  ua_out;            // upper address
    wire        bus_oe, ua_oe, ale, oe_n, ce_n, wrh_n, wrl_n, ub_n, lb_n, ba;
    reg  [15:0] n_ale, n_oe, a_seen, u_seen, d_seen, sel_seen; // pin monitor
    reg  [7:0]  n_wrh, n_wrl;      // strobe cycle counts
    reg  [15:0] miscompares = 16'h0000; // mismatches
    reg  [15:0] comparisons = 16'h0000; // checks made
    integer     seed = 32'he791c391; // fixed seed
    integer     m, l;              // mode and lane loops
    reg  [1:0]  wc;                // wait code
    reg  [19:0] tp;                // table pointer
    reg  [7:0]  tl, hold, rd_v;    // latch byte, held byte, read value
    reg  [15:0] w;                 // expected memory word
    xmb_ext_bus dut
    (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_req(sleep_req),
        .muxed_addr_data_bus_in(bus_in), .muxed_addr_data_bus_out(bus_out),
        .muxed_addr_data_bus_oe(bus_oe), .upper_addr_out(ua_out),
        .upper_addr_oe(ua_oe), .address_latch_strobe(ale),
        .output_enable_n(oe_n), .chip_enable_n(ce_n),
        .write_high_strobe_n(wrh_n), .write_low_strobe_n(wrl_n),
        .upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n),
        .byte_address_line(ba)
    );
    xmb_mem_model mem
    (
        .core_clk(core_clk), .bus_out(bus_out), .bus_oe(bus_oe), .ale(ale),
        .oe_n(oe_n), .ce_n(ce_n), .ub_n(ub_n), .lb_n(lb_n), .bus_in(bus_in)
    );
    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;
    // record what each bus cycle shows on the pins
    always @(posedge core_clk)
    begin
        if (ale)
        begin
            n_ale = n_ale + 16'h0001;
            a_seen = bus_out;
            u_seen = {12'h000, ua_out};
        end
        if (!wrh_n || !wrl_n)
        begin
            d_seen = bus_out;
            sel_seen = {13'h0000, ba, ub_n, lb_n};
        end
        n_wrh = n_wrh + {7'h00, !wrh_n};
        n_wrl = n_wrl + {7'h00, !wrl_n};
        n_oe = n_oe + {15'h0000, !oe_n};
    end
    // strobe counts {high, low} for one table write
    function [15:0] exp_wr(input [1:0] md, input ln, input [7:0] nd);
        exp_wr = {(md[1] || ln) ? nd : 8'h00, (md == 2'h0 && !ln) ? nd : 8'h00};
    endfunction
    // {byte line, upper enable, lower enable} during a strobe
    function [15:0] exp_sel(input [1:0] md, input ln);
        exp_sel = md[1] ? {13'h0000, ln, !ln, ln} : {13'h0000, ln & md[0], 2'b00};
    endfunction
    // compare and count
    task chk(input string what, input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 16'h0001;
            if (seen !== exp)
            begin
                miscompares = miscompares + 16'h0001;
                $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one-cycle register write
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    // one-cycle register read, data taken the cycle after
    task rd(input [3:0] a);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 rd_v = reg_rdata;
        end
    endtask
    // clear the pin monitor counts away from the edge
    task clr;
        begin
            #1;
            n_ale = 16'h0000;
            n_oe = 16'h0000;
            n_wrh = 8'h00;
            n_wrl = 8'h00;
        end
    endtask
    // poll status until not busy, bounded
    task wait_idle;
        integer k;
        begin
            rd_v = 8'h01;
            for (k = 0; k < 40 && rd_v[0] !== 1'b0; k = k + 1)
                rd(`XMB_REG_STAT);
            chk("idle", {15'h0000, rd_v[0]}, 16'h0000);
        end
    endtask
    // load control, pointer and latch byte
    task prep(input [7:0] ctrl, input [19:0] p, input [7:0] t);
        begin
            wr(`XMB_REG_CTRL, ctrl);
            wr(`XMB_REG_TPTR_L, p[7:0]);
            wr(`XMB_REG_TPTR_H, p[15:8]);
            wr(`XMB_REG_TPTR_U, {4'h0, p[19:16]});
            wr(`XMB_REG_TLAT, t);
        end
    endtask
    // issue a command and wait for the cycle to end
    task op(input [7:0] cmd);
        begin
            clr;
            wr(`XMB_REG_CMD, cmd);
            wait_idle;
        end
    endtask
    // verdict
    task tally_and_finish;
        begin
            $display("comparisons %0d miscompares %0d", comparisons, miscompares);
            if (miscompares == 16'h0000 && comparisons != 16'h0000)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // watchdog
    initial
    begin
        repeat (30000) @(posedge core_clk);
        miscompares = miscompares + 16'h0001;
        tally_and_finish;
    end
    // main sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rd(`XMB_REG_CTRL);
        chk("ctrl_rst", {8'h00, rd_v}, 16'h0000);
        wr(`XMB_REG_CTRL, 8'hff);
        rd(`XMB_REG_CTRL);
        chk("ctrl_mask", {8'h00, rd_v}, 16'h0033);
        rd(4'hf);
        chk("unmapped", {8'h00, rd_v}, 16'h0000);
        // every write mode code, both lanes, random wait
        for (m = 0; m < 4; m = m + 1)
            for (l = 0; l < 2; l = l + 1)
            begin
                wc = $random(seed);
                tl = $random(seed);
                if (l == 0)
                    tp = $random(seed);
                tp[0] = l[0]; // even then odd in one word
                prep({2'h0, wc, 2'h0, m[1:0]}, tp, tl);
                op(8'h01);
                chk("ale", n_ale, 16'h0001);
                chk("addr", a_seen, tp[15:0]);
                chk("uaddr", u_seen, {12'h000, tp[19:16]});
                chk("strobes", {n_wrh, n_wrl},
                    exp_wr(m[1:0], l[0], 8'h04 - {6'h00, wc}));
                if (m != 1 || l == 1)
                begin
                    chk("data", d_seen, {tl, (m == 1) ? hold : tl});
                    chk("select", sel_seen, exp_sel(m[1:0], l[0]));
                end
                hold = tl;
            end
        // table reads and fetches in every mode
        for (m = 0; m < 4; m = m + 1)
        begin
            wc = $random(seed);
            tp = $random(seed);
            prep({2'h0, wc, 2'h0, m[1:0]}, tp, 8'h00);
            op(8'h02);
            w = tp[15:0] ^ 16'h3c5a;
            chk("rd_span", n_oe, 16'h0008 - {14'h0000, wc});
            rd(`XMB_REG_TLAT);
            chk("rd_byte", {8'h00, rd_v}, {8'h00, tp[0] ? w[15:8] : w[7:0]});
            op(8'h04);
            chk("fetch_span", n_oe, 16'h0005);
            rd(`XMB_REG_FETCH_L);
            chk("fetch_lo", {8'h00, rd_v}, {8'h00, w[7:0]});
            rd(`XMB_REG_FETCH_H);
            chk("fetch_hi", {8'h00, rd_v}, {8'h00, w[15:8]});
        end
        // sleep arriving mid-cycle, then a refused request
        prep(8'h00, 20'h00102, 8'h5a);
        clr;
        wr(`XMB_REG_CMD, 8'h01);
        repeat (2) @(posedge core_clk);
        sleep_req <= 1'b1;
        wait_idle;
        chk("stat_sleep", {8'h00, rd_v}, 16'h0002);
        op(8'h01);
        chk("refused", n_ale, 16'h0000);
        sleep_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        tally_and_finish;
    end
endmodule // test_ext_mem_bus_16bit_modes
